//--- verilog/scrb_bank.sv
// System control register bank, registers 1 to 6
`default_nettype none
module scrb_bank (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_vector_init_pin,
    // Transfer link
    scrb_if.bank bus,
    // Abort capture
    input wire logic i_data_abort,
    input wire logic i_prefetch_abort,
    input wire logic [3:0] i_abort_domain,
    input wire logic [3:0] i_abort_type,
    input wire logic [31:0] i_abort_mva,
    // Control outputs
    output logic o_mmu_enable,
    output logic o_align_check,
    output logic o_dcache_enable,
    output logic o_icache_enable,
    output logic o_big_endian,
    output logic o_system_protect,
    output logic o_rom_protect,
    output logic o_round_robin_select,
    output logic [31:0] o_vector_base,
    output scrb_pkg::scrb_clkmode_t o_clock_mode,
    output logic [17:0] o_translation_base_pointer,
    output logic [31:0] o_domain_fields
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] translation_base_pointer;
        logic [31:0] dom;
        logic [7:0] dfsr;
        logic [7:0] pfsr;
        logic [31:0] fault_address_capture;
        logic [31:0] rdata;
        logic undef;
    } scrb_bank_st_t;
    scrb_bank_st_t st_q;
    scrb_bank_st_t st_d;
    logic hit;
    logic legal;
    always_comb begin
        st_d = st_q;
        // Opcode 1 and CRm must be zero; register 4 is excluded [R21] [R15]
        legal = bus.xfer_op1 == 3'h0 && bus.xfer_crm == 4'h0 &&
            bus.xfer_crn >= scrb_pkg::SCRB_CRN_CTRL &&
            bus.xfer_crn <= scrb_pkg::SCRB_CRN_FAR &&
            bus.xfer_crn != scrb_pkg::SCRB_CRN_RSVD;
        hit = bus.xfer_valid && bus.xfer_priv && legal;
        st_d.undef = bus.xfer_valid && !bus.xfer_priv; // [R22]
        // Abort capture; a software write in the same cycle loses
        if (i_data_abort) begin
            st_d.dfsr = {i_abort_domain, i_abort_type}; // [R16]
            st_d.fault_address_capture = i_abort_mva; // [R20]
        end
        if (i_prefetch_abort) begin
            st_d.pfsr = {i_abort_domain, i_abort_type};
        end
        st_d.rdata = scrb_pkg::SCRB_ZERO;
        if (hit && bus.xfer_write) begin
            case (bus.xfer_crn)
                scrb_pkg::SCRB_CRN_CTRL: begin
                    st_d.ctrl = bus.xfer_wdata & scrb_pkg::SCRB_CTRL_MASK; // [R24] [R3]
                end
                scrb_pkg::SCRB_CRN_TTB: begin
                    st_d.translation_base_pointer = bus.xfer_wdata & scrb_pkg::SCRB_TTB_MASK; // [R13]
                end
                scrb_pkg::SCRB_CRN_DOM: begin
                    st_d.dom = bus.xfer_wdata; // [R14]
                end
                scrb_pkg::SCRB_CRN_FSR: begin
                    // Restore path for a debugger [R19] [R18]
                    if (bus.xfer_op2 == scrb_pkg::SCRB_OP2_PREF) begin
                        if (!i_prefetch_abort) begin
                            st_d.pfsr = bus.xfer_wdata[7:0];
                        end
                    end else if (!i_data_abort) begin
                        st_d.dfsr = bus.xfer_wdata[7:0];
                    end
                end
                scrb_pkg::SCRB_CRN_FAR: begin
                    if (!i_data_abort) begin
                        st_d.fault_address_capture = bus.xfer_wdata; // [R20]
                    end
                end
                default: begin
                end
            endcase
        end
        if (hit && !bus.xfer_write) begin
            case (bus.xfer_crn)
                scrb_pkg::SCRB_CRN_CTRL: begin
                    st_d.rdata = st_q.ctrl | scrb_pkg::SCRB_CTRL_ONES;
                end
                scrb_pkg::SCRB_CRN_TTB: begin
                    st_d.rdata = st_q.translation_base_pointer; // [R12]
                end
                scrb_pkg::SCRB_CRN_DOM: begin
                    st_d.rdata = st_q.dom; // [R14]
                end
                scrb_pkg::SCRB_CRN_FSR: begin
                    // Bit 8 and above read zero [R17] [R18]
                    st_d.rdata = {24'h000000,
                        (bus.xfer_op2 == scrb_pkg::SCRB_OP2_PREF) ?
                        st_q.pfsr : st_q.dfsr};
                end
                scrb_pkg::SCRB_CRN_FAR: begin
                    st_d.rdata = st_q.fault_address_capture; // [R23]
                end
                default: begin
                    st_d.rdata = scrb_pkg::SCRB_ZERO;
                end
            endcase
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            // Strap tracked while reset is held, so no write can race it
            st_q <= '0; // [R1]
            st_q.ctrl[scrb_pkg::SCRB_B_VECHI] <= i_vector_init_pin; // [R2]
        end else begin
            st_q <= st_d;
        end
    end
    assign bus.xfer_rdata = st_q.rdata;
    assign bus.xfer_undef = st_q.undef;
    // Control word fans out to the core [R5] [R7] [R8] [R9] [R10]
    assign o_mmu_enable = st_q.ctrl[scrb_pkg::SCRB_B_MMU];
    assign o_align_check = st_q.ctrl[scrb_pkg::SCRB_B_ALIGN];
    assign o_dcache_enable = st_q.ctrl[scrb_pkg::SCRB_B_DCACHE];
    assign o_icache_enable = st_q.ctrl[scrb_pkg::SCRB_B_ICACHE];
    assign o_big_endian = st_q.ctrl[scrb_pkg::SCRB_B_BIGEND];
    assign o_system_protect = st_q.ctrl[scrb_pkg::SCRB_B_SYSPROT];
    assign o_rom_protect = st_q.ctrl[scrb_pkg::SCRB_B_ROMPROT];
    assign o_round_robin_select = st_q.ctrl[scrb_pkg::SCRB_B_RROBIN];
    assign o_vector_base = st_q.ctrl[scrb_pkg::SCRB_B_VECHI] ?
        scrb_pkg::SCRB_VEC_HI : scrb_pkg::SCRB_VEC_LO; // [R6]
    assign o_clock_mode = scrb_pkg::scrb_clkmode_t'(
        {st_q.ctrl[scrb_pkg::SCRB_B_ASYNC],
        st_q.ctrl[scrb_pkg::SCRB_B_NFAST]}); // [R11]
    assign o_translation_base_pointer = st_q.translation_base_pointer[31:14];
    assign o_domain_fields = st_q.dom;
endmodule : scrb_bank
`default_nettype wire

//--- verilog/scrb_pkg.sv
// Package for the system control register bank and its transfer port
// Notes on behaviour
// R1: Reset clears every defined control bit except vector base
// R2: Vector base bit loads vector-init pin during reset
// R3: Control bits 29:15 reserved, written as zero
// R4: Software keeps fixed reserved bits or read-modify-writes
// R5: Bit 14 picks round-robin over random replacement
// R6: Bit 13 moves vectors to high base
// R7: Bits 12, 2, 0 enable icache, dcache, MMU
// R8: Bits 9, 8 feed MMU protection checks
// R9: Bit 7 selects big-endian byte order
// R10: Bit 1 enables alignment fault checking
// R11: Bits 31:30 select clocking mode; 10 reserved
// R12: Translation base reads return pointer in 31:14
// R13: Translation base writes take bits 31:14 only
// R14: Sixteen 2-bit domain fields, read and write
// R15: Software never touches register number four
// R16: Data abort captures domain and fault type
// R17: Fault status bit 8 reads zero
// R18: Secondary opcode 1 selects prefetch fault status
// R19: Debugger restores fault status by read-modify-write
// R20: Fault address captured on data faults only
// R21: Registers 1 to 6, other opcodes zero
// R22: Unprivileged transfers raise undefined instruction trap
// R23: Captured fault values held until replaced
// R24: Control writes take effect next cycle
`default_nettype none
package scrb_pkg;
    localparam logic [3:0] SCRB_CRN_CTRL = 4'h1;
    localparam logic [3:0] SCRB_CRN_TTB = 4'h2;
    localparam logic [3:0] SCRB_CRN_DOM = 4'h3;
    localparam logic [3:0] SCRB_CRN_RSVD = 4'h4;
    localparam logic [3:0] SCRB_CRN_FSR = 4'h5;
    localparam logic [3:0] SCRB_CRN_FAR = 4'h6;
    localparam logic [2:0] SCRB_OP2_DATA = 3'h0;
    localparam logic [2:0] SCRB_OP2_PREF = 3'h1;
    // Control word bit positions
    localparam int SCRB_B_MMU = 0;
    localparam int SCRB_B_ALIGN = 1;
    localparam int SCRB_B_DCACHE = 2;
    localparam int SCRB_B_BIGEND = 7;
    localparam int SCRB_B_SYSPROT = 8;
    localparam int SCRB_B_ROMPROT = 9;
    localparam int SCRB_B_ICACHE = 12;
    localparam int SCRB_B_VECHI = 13;
    localparam int SCRB_B_RROBIN = 14;
    localparam int SCRB_B_NFAST = 30;
    localparam int SCRB_B_ASYNC = 31;
    // Writable defined bits and fixed-one reserved bits
    localparam logic [31:0] SCRB_CTRL_MASK = 32'hC000_7387;
    localparam logic [31:0] SCRB_CTRL_ONES = 32'h0000_0078;
    localparam logic [31:0] SCRB_TTB_MASK = 32'hFFFF_C000;
    localparam logic [31:0] SCRB_FSR_MASK = 32'h0000_00FF;
    localparam logic [31:0] SCRB_ZERO = 32'h0000_0000;
    localparam logic [31:0] SCRB_VEC_LO = 32'h0000_0000;
    localparam logic [31:0] SCRB_VEC_HI = 32'hFFFF_0000;
    // Host register offsets (byte addresses)
    localparam logic [3:0] SCRB_H_CMD = 4'h0;
    localparam logic [3:0] SCRB_H_WDATA = 4'h4;
    localparam logic [3:0] SCRB_H_RDATA = 4'h8;
    localparam logic [3:0] SCRB_H_STAT = 4'hC;
    // Command register fields
    localparam int SCRB_C_CRN = 0;
    localparam int SCRB_C_OP2 = 4;
    localparam int SCRB_C_WR = 8;
    localparam int SCRB_C_PRIV = 9;
    typedef enum logic [1:0] {
        SCRB_CLK_FAST = 2'b00,
        SCRB_CLK_SYNC = 2'b01,
        SCRB_CLK_RSVD = 2'b10,
        SCRB_CLK_ASYNC = 2'b11
    } scrb_clkmode_t;
endpackage : scrb_pkg
`default_nettype wire

//--- verilog/scrb_if.sv
// Coprocessor transfer link between core-side master and register bank
`default_nettype none
interface scrb_if;
    logic xfer_valid;
    logic xfer_write;
    logic xfer_priv;
    logic [3:0] xfer_crn;
    logic [3:0] xfer_crm;
    logic [2:0] xfer_op1;
    logic [2:0] xfer_op2;
    logic [31:0] xfer_wdata;
    logic [31:0] xfer_rdata;
    logic xfer_undef;
    modport bank (
        input xfer_valid, xfer_write, xfer_priv, xfer_crn, xfer_crm,
        input xfer_op1, xfer_op2, xfer_wdata,
        output xfer_rdata, xfer_undef
    );
    modport core (
        output xfer_valid, xfer_write, xfer_priv, xfer_crn, xfer_crm,
        output xfer_op1, xfer_op2, xfer_wdata,
        input xfer_rdata, xfer_undef
    );
endinterface : scrb_if
`default_nettype wire

//--- verilog/scrb_core.sv
// Core-side transfer master driven by software command registers
`default_nettype none
module scrb_core (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Software port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Transfer link
    scrb_if.core bus
);
    typedef struct packed {
        logic [9:0] cmd;
        logic [31:0] wdata;
        logic [31:0] rcap;
        logic go;
        logic pend;
        logic undef;
        logic [31:0] rdata;
    } scrb_core_st_t;
    scrb_core_st_t st_q;
    scrb_core_st_t st_d;
    logic [31:0] stat;
    always_comb begin
        st_d = st_q;
        st_d.go = 1'b0;
        st_d.pend = st_q.go && !st_q.cmd[scrb_pkg::SCRB_C_WR];
        if (st_q.pend) begin
            st_d.rcap = bus.xfer_rdata;
        end
        // Trap sticks until the next command; new trap wins over clear
        if (bus.xfer_undef) begin
            st_d.undef = 1'b1; // [R22]
        end else if (i_wr && i_addr == scrb_pkg::SCRB_H_CMD) begin
            st_d.undef = 1'b0;
        end
        if (i_wr && i_addr == scrb_pkg::SCRB_H_CMD) begin
            st_d.cmd = i_wdata[9:0];
            st_d.go = 1'b1;
        end
        if (i_wr && i_addr == scrb_pkg::SCRB_H_WDATA) begin
            st_d.wdata = i_wdata;
        end
        stat = {30'h0, st_q.undef, st_q.go || st_q.pend};
        st_d.rdata = scrb_pkg::SCRB_ZERO;
        if (i_rd) begin
            case (i_addr)
                scrb_pkg::SCRB_H_CMD: st_d.rdata = {22'h0, st_q.cmd};
                scrb_pkg::SCRB_H_WDATA: st_d.rdata = st_q.wdata;
                scrb_pkg::SCRB_H_RDATA: st_d.rdata = st_q.rcap;
                scrb_pkg::SCRB_H_STAT: st_d.rdata = stat;
                default: st_d.rdata = scrb_pkg::SCRB_ZERO;
            endcase
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign o_rdata = st_q.rdata;
    // Opcode 1 and CRm always zero [R21]
    assign bus.xfer_valid = st_q.go;
    assign bus.xfer_write = st_q.cmd[scrb_pkg::SCRB_C_WR];
    assign bus.xfer_priv = st_q.cmd[scrb_pkg::SCRB_C_PRIV];
    assign bus.xfer_crn = st_q.cmd[3:0];
    assign bus.xfer_op2 = st_q.cmd[6:4];
    assign bus.xfer_crm = 4'h0;
    assign bus.xfer_op1 = 3'h0;
    assign bus.xfer_wdata = st_q.wdata;
endmodule : scrb_core
`default_nettype wire

//--- test/scrb_props.sv
// Link checker for the control register bank transfers
`default_nettype none
module scrb_props (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Link signals
    input wire logic xfer_valid,
    input wire logic xfer_write,
    input wire logic xfer_priv,
    input wire logic [3:0] xfer_crn,
    input wire logic [3:0] xfer_crm,
    input wire logic [2:0] xfer_op1,
    input wire logic [2:0] xfer_op2,
    input wire logic [31:0] xfer_wdata,
    input wire logic [31:0] xfer_rdata,
    input wire logic xfer_undef
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_acc(w, logic [3:0] n);
        xfer_valid && xfer_priv && xfer_write == w && xfer_crn == n
            && xfer_crm == 4'h0 && xfer_op1 == 3'h0 && xfer_op2 == 3'h0;
    endsequence
    // Read straight after a write must already see the new value
    property p_back(logic [3:0] n, logic [31:0] m);
        s_acc(1'h1, n) ##1 s_acc(1'h0, n) |=>
            (xfer_rdata & m) == ($past(xfer_wdata, 2) & m);
    endproperty
    a_undef_raise: assert property (xfer_valid && !xfer_priv |=> xfer_undef)
        else $error("no trap after unprivileged transfer");
    a_undef_quiet: assert property (!(xfer_valid && !xfer_priv) |=> !xfer_undef)
        else $error("trap without unprivileged transfer");
    a_ctrl_fixed: assert property (s_acc(1'h0, 4'h1) |=> (xfer_rdata & 32'h3FFF_8C78) == 32'h0000_0078)
        else $error("control reserved bits read wrong");
    a_ttb_low: assert property (s_acc(1'h0, 4'h2) |=> xfer_rdata[13:0] == 14'h0000)
        else $error("table base low bits not zero");
    a_fsr_bit8: assert property (xfer_valid && xfer_priv && !xfer_write && xfer_crn == 4'h5 |=> xfer_rdata[31:8] == 24'h0)
        else $error("fault status upper bits not zero");
    a_unmap_zero: assert property (s_acc(1'h0, 4'h7) |=> xfer_rdata == 32'h0)
        else $error("unmapped register read not zero");
    a_rdata_idle: assert property (!(xfer_valid && !xfer_write) |=> xfer_rdata == 32'h0)
        else $error("read data outside a read answer");
    a_ctrl_back: assert property (p_back(4'h1, 32'hC000_7387))
        else $error("control write not seen by next read");
    a_ttb_back: assert property (p_back(4'h2, 32'hFFFF_C000))
        else $error("table base write not seen by next read");
    a_dom_back: assert property (p_back(4'h3, 32'hFFFF_FFFF))
        else $error("domain write not seen by next read");
endmodule : scrb_props
`default_nettype wire

//--- test/scrb_tb_top.sv
// Bench for the control register bank and its core-side master
`default_nettype none
module scrb_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk, i_rst, i_wr, i_rd, vinit, dab, pab;
    logic mmu, al, dc, ic, be, sp, rp, rr;
    logic [3:0] i_addr, dom, typ, c;
    logic [2:0] o;
    logic [31:0] i_wdata, o_rdata, modified_virtual_address, got, d, vb, df;
    logic [31:0] m [0:7];
    logic [17:0] tp;
    scrb_pkg::scrb_clkmode_t cm;
    int errors = 0, n_tests = 0, cyc = 0;
    scrb_if bus_if ();
    scrb_bank u_scrb_bank (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_vector_init_pin(vinit), .bus(bus_if), .i_data_abort(dab),
        .i_prefetch_abort(pab), .i_abort_domain(dom), .i_abort_type(typ),
        .i_abort_mva(modified_virtual_address), .o_mmu_enable(mmu), .o_align_check(al),
        .o_dcache_enable(dc), .o_icache_enable(ic), .o_big_endian(be),
        .o_system_protect(sp), .o_rom_protect(rp),
        .o_round_robin_select(rr), .o_vector_base(vb), .o_clock_mode(cm),
        .o_translation_base_pointer(tp), .o_domain_fields(df));
    scrb_core u_scrb_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .bus(bus_if));
    scrb_props u_scrb_props (.i_mclk(i_mclk), .i_rst(i_rst),
        .xfer_valid(bus_if.xfer_valid), .xfer_write(bus_if.xfer_write),
        .xfer_priv(bus_if.xfer_priv), .xfer_crn(bus_if.xfer_crn),
        .xfer_crm(bus_if.xfer_crm), .xfer_op1(bus_if.xfer_op1),
        .xfer_op2(bus_if.xfer_op2), .xfer_wdata(bus_if.xfer_wdata),
        .xfer_rdata(bus_if.xfer_rdata), .xfer_undef(bus_if.xfer_undef));
    initial begin
        i_mclk = 1'h0;
        forever #25 i_mclk = ~i_mclk;
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [31:0] keep(input logic [3:0] n);
        case (n)
            4'h1: keep = 32'hC000_7387;
            4'h2: keep = 32'hFFFF_C000;
            4'h5: keep = 32'h0000_00FF;
            default: keep = 32'hFFFF_FFFF;
        endcase
    endfunction : keep
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] v);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_mclk);
    endtask : bus
    task automatic idle(input int n);
        i_wr <= 1'h0;
        i_rd <= 1'h0;
        repeat (n) @(posedge i_mclk);
    endtask : idle
    // Read data stand only in the cycle after the strobe
    task automatic peek(input logic [3:0] a);
        bus(1'h0, a, 32'h0);
        idle(0);
        #1 got = o_rdata;
        @(posedge i_mclk);
    endtask : peek
    task automatic xfer(input logic [3:0] n, input logic [2:0] p,
        input logic w, input logic pv, input logic [31:0] v);
        bus(1'h1, 4'h4, v);
        bus(1'h1, 4'h0, {22'h0, pv, w, 1'h0, p, n});
        idle(3);
        peek(4'h8);
    endtask : xfer
    task automatic outs;
        chk({22'h0, cm, rr, ic, rp, sp, be, dc, al, mmu},
            {22'h0, m[1][31:30], m[1][14], m[1][12], m[1][9:7], m[1][2:0]});
        chk(vb, m[1][13] ? 32'hFFFF_0000 : 32'h0);
        chk({14'h0, tp}, {14'h0, m[2][31:14]});
        chk(df, m[3]);
    endtask : outs
    initial begin
        {i_wr, i_rd, dab, pab, vinit, i_rst} = 6'h01;
        {i_addr, dom, typ} = 12'h0;
        {i_wdata, modified_virtual_address} = 64'h0;
        d = $urandom(18138);
        for (int v = 0; v < 2; v++) begin
            i_rst <= 1'h1;
            vinit <= v[0];
            repeat (12) @(posedge i_mclk);
            i_rst <= 1'h0;
            m = '{default: 32'h0};
            m[1] = {18'h0, v[0], 13'h0078};
            idle(2);
            outs;
            for (int k = 1; k < 8; k++) begin
                if (k == 4) continue;
                xfer(4'(k), 3'h0, 1'h0, 1'h1, 32'h0);
                chk(got, m[k]);
            end
        end
        for (int i = 0; i < 60; i++) begin
            c = 4'($urandom_range(6, 1));
            if (c == 4'h4) c = 4'h3;
            o = (c == 4'h5) ? 3'($urandom_range(1, 0)) : 3'h0;
            d = $urandom & keep(c);
            // Reserved clock mode is never written
            if (c == 4'h1) d = d | 32'h78 | {1'h0, d[31], 30'h0};
            xfer(c, o, 1'h1, 1'h1, d);
            m[o[0] ? 7 : c] = d;
            xfer(c, o, 1'h0, 1'h1, 32'h0);
            chk(got, m[o[0] ? 7 : c]);
            outs;
        end
        xfer(4'h3, 3'h0, 1'h1, 1'h0, ~m[3]);
        peek(4'hC);
        chk(got & 32'h2, 32'h2);
        xfer(4'h3, 3'h0, 1'h0, 1'h1, 32'h0);
        chk(got, m[3]);
        for (int k = 1; k < 4; k++) begin
            d = ($urandom & keep(4'(k))) | ((k == 1) ? 32'h78 : 32'h0);
            d[31] = d[31] & d[30];
            bus(1'h1, 4'h4, d);
            bus(1'h1, 4'h0, {22'h0, 2'h3, 4'h0, 4'(k)});
            bus(1'h1, 4'h0, {22'h0, 2'h2, 4'h0, 4'(k)});
            idle(3);
            peek(4'h8);
            m[k] = d;
            chk(got, m[k]);
        end
        peek(4'h2);
        chk(got, 32'h0);
        dom <= 4'($urandom);
        typ <= 4'($urandom);
        modified_virtual_address <= $urandom;
        dab <= 1'h1;
        @(posedge i_mclk);
        dab <= 1'h0;
        pab <= 1'h1;
        m[5] = {24'h0, dom, typ};
        m[6] = modified_virtual_address;
        dom <= ~dom;
        modified_virtual_address <= ~modified_virtual_address;
        @(posedge i_mclk);
        pab <= 1'h0;
        m[7] = {24'h0, dom, typ};
        xfer(4'h5, 3'h0, 1'h0, 1'h1, 32'h0);
        chk(got, m[5]);
        xfer(4'h5, 3'h1, 1'h0, 1'h1, 32'h0);
        chk(got, m[7]);
        xfer(4'h6, 3'h0, 1'h0, 1'h1, 32'h0);
        chk(got, m[6]);
        report_and_stop;
    end
endmodule : scrb_tb_top
`default_nettype wire
